// *** rtl/wave_defs.svh ***
`ifndef WAVE_DEFS_SVH
`define WAVE_DEFS_SVH

// Register byte addresses
`define ADDR_CONTROL_0 12'h000
`define ADDR_CONTROL_1 12'h004
`define ADDR_SOURCE_SEL 12'h008
`define ADDR_OVERRIDE 12'h00C
`define ADDR_STATUS 12'h010

// Control 0 fields
`define CTL0_EN_BIT 7
`define CTL0_LD_BIT 6
`define CTL0_MODE_LSB 0
`define CTL0_RESET 8'h00
`define CTL0_WMASK 8'hC7

// Other reset values
`define CTL1_RESET 8'h00
`define SRC_RESET 4'h0
`define OVR_RESET 8'h00
`define MODE_RESET 3'h0
`define WAVE_RESET 4'h0

// Source count
`define SRC_COUNT 14

`endif

// *** rtl/wave_pkg.sv ***
package wave_pkg;
    typedef enum logic [2:0] {
        MODE_STEER = 3'h0,
        MODE_SYNC_STEER = 3'h1,
        MODE_FWD_FULL = 3'h2,
        MODE_REV_FULL = 3'h3,
        MODE_HALF = 3'h4,
        MODE_PUSH_PULL = 3'h5
    } out_mode_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;
endpackage : wave_pkg

// *** rtl/waveform_gen_control.sv ***
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "wave_defs.svh"

module waveform_gen_control
    import wave_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // APB slave
    input wire apb_req_t apb_i,
    output var apb_rsp_t apb_o,
    // Input sources
    input wire logic [13:0] sources_i,
    input wire logic shutdown_i,
    // Waveform outputs
    output var logic [3:0] wave_o,
    output var logic enabled_o
);

    // Registers are one byte wide; upper lanes read zero
    function automatic logic [31:0] zext8(input logic [7:0] v);
        zext8 = {24'h000000, v};
    endfunction : zext8

    // Register select, shared by every register
    function automatic logic addr_hit(
        input logic [11:0] addr,
        input logic [11:0] offset
    );
        addr_hit = (addr == offset);
    endfunction : addr_hit

    // Set polarity bit passes the level, cleared bit inverts it
    function automatic logic [3:0] apply_pol(
        input logic [3:0] level,
        input logic [3:0] pol
    );
        apply_pol = level ~^ pol;
    endfunction : apply_pol

    // Software-visible registers
    logic [7:0] ctl0_r;
    logic [7:0] ctl1_r;
    logic [3:0] src_sel_r;
    logic [7:0] ovr_r;

    // Active copies of the buffered settings
    logic [7:0] ctl1_act_r;
    logic [2:0] mode_act_r;

    // Input tracking and output state
    logic in_prev_r;
    logic dir_r;
    logic [3:0] wave_r;
    apb_rsp_t rsp_r;

    // Next values
    logic [7:0] ctl0_nxt;
    logic [7:0] ctl1_nxt;
    logic [3:0] src_sel_nxt;
    logic [7:0] ovr_nxt;
    logic [7:0] ctl1_act_nxt;
    logic [2:0] mode_act_nxt;
    logic dir_nxt;
    logic [3:0] wave_nxt;
    apb_rsp_t rsp_nxt;

    // Combinational helpers
    logic [3:0] raw;
    logic [7:0] rd_byte;

    // Bus phase decode
    wire access = apb_i.psel && apb_i.penable;
    wire first_acc = access && !rsp_r.pready;
    // Writes land on the pready edge only, so each access writes once
    wire wr_acc = access && rsp_r.pready && apb_i.pwrite;
    wire rd_acc = first_acc && !apb_i.pwrite;

    // Address decode
    wire hit_c0 = addr_hit(apb_i.paddr, `ADDR_CONTROL_0);
    wire hit_c1 = addr_hit(apb_i.paddr, `ADDR_CONTROL_1);
    wire hit_src = addr_hit(apb_i.paddr, `ADDR_SOURCE_SEL);
    wire hit_ovr = addr_hit(apb_i.paddr, `ADDR_OVERRIDE);
    wire hit_st = addr_hit(apb_i.paddr, `ADDR_STATUS);
    wire mapped = hit_c0 | hit_c1 | hit_src | hit_ovr | hit_st;

    // Write strobes; status is read only
    wire [7:0] wbyte = apb_i.pwdata[7:0];
    wire wr_c0 = wr_acc && hit_c0;
    wire wr_c1 = wr_acc && hit_c1;
    wire wr_src = wr_acc && hit_src;
    wire wr_ovr = wr_acc && hit_ovr;

    // Single source mux; codes 14 and 15 give a constant low
    wire src_ok = src_sel_r < 4'(`SRC_COUNT);
    wire in_sig = src_ok && sources_i[src_sel_r];
    wire in_rise = in_sig && !in_prev_r;
    wire in_fall = !in_sig && in_prev_r;
    wire in_edge = in_rise || in_fall;

    // Control fields
    wire en = ctl0_r[`CTL0_EN_BIT];
    wire ld = ctl0_r[`CTL0_LD_BIT];

    // Load bit accepted only if enable already set
    wire ld_set = wr_c0 && wbyte[`CTL0_LD_BIT] && en;
    wire ld_fire = ld && en && in_edge;

    // Control 0 next value; a set in the event cycle wins
    always_comb begin
        ctl0_nxt = ctl0_r;
        if (wr_c0) begin
            ctl0_nxt = wbyte & `CTL0_WMASK;
            ctl0_nxt[`CTL0_LD_BIT] = ld_set | ld;
        end
        if (ld_fire && !ld_set) begin
            ctl0_nxt[`CTL0_LD_BIT] = 1'b0;
        end
        if (!ctl0_nxt[`CTL0_EN_BIT]) begin
            ctl0_nxt[`CTL0_LD_BIT] = 1'b0;
        end
    end

    // Other register next values
    always_comb begin
        ctl1_nxt = ctl1_r;
        src_sel_nxt = src_sel_r;
        ovr_nxt = ovr_r;
        if (wr_c1) begin
            ctl1_nxt = wbyte;
        end
        if (wr_src) begin
            src_sel_nxt = wbyte[3:0];
        end
        if (wr_ovr) begin
            ovr_nxt = wbyte;
        end
    end

    // Buffers track the next values while off, so the enabling
    // write already brings its own mode; once on, only a load moves them
    always_comb begin
        ctl1_act_nxt = ctl1_act_r;
        mode_act_nxt = mode_act_r;
        if (!en || ld_fire) begin
            ctl1_act_nxt = ctl1_nxt;
            mode_act_nxt = ctl0_nxt[`CTL0_MODE_LSB +: 3];
        end
    end

    // Raw steering, before polarity
    always_comb begin
        raw = 4'h0;
        unique case (mode_act_r)
            MODE_STEER: begin
                raw = {4{in_sig}} & ctl1_act_r[7:4];
            end
            MODE_SYNC_STEER: begin
                raw = {4{in_sig}} & ctl1_act_r[7:4];
            end
            MODE_FWD_FULL: begin
                raw = {1'b0, in_sig, 1'b0, 1'b1};
            end
            MODE_REV_FULL: begin
                raw = {1'b1, 1'b0, in_sig, 1'b0};
            end
            MODE_HALF: begin
                raw = {2'h0, !in_sig, in_sig};
            end
            MODE_PUSH_PULL: begin
                raw = {2'h0, in_sig & dir_r, in_sig & !dir_r};
            end
            default: begin
                // Reserved codes hold every output inactive
                raw = 4'h0;
            end
        endcase
    end

    // Push-pull alternates on each input rising edge
    always_comb begin
        dir_nxt = dir_r;
        if (in_rise) begin
            dir_nxt = !dir_r;
        end
    end

    // Polarity on normal path only; override bypasses it
    wire [3:0] pol = ctl1_act_r[3:0];
    wire [3:0] shaped = apply_pol(raw, pol);
    wire [3:0] ovr_en = ovr_r[7:4] | {4{shutdown_i}};
    wire [3:0] ovr_lvl = ovr_r[3:0];

    // Disabled module shows the override levels
    always_comb begin
        wave_nxt = ovr_lvl;
        if (en) begin
            wave_nxt = (shaped & ~ovr_en) | (ovr_lvl & ovr_en);
        end
    end

    // Read mux; status shows the active mode
    always_comb begin
        rd_byte = 8'h00;
        if (hit_c0) begin
            rd_byte = ctl0_r;
        end else if (hit_c1) begin
            rd_byte = ctl1_r;
        end else if (hit_src) begin
            rd_byte = {4'h0, src_sel_r};
        end else if (hit_ovr) begin
            rd_byte = ovr_r;
        end else if (hit_st) begin
            rd_byte = {5'h00, mode_act_r};
        end
    end

    // One wait state: pready in the second access cycle
    always_comb begin
        rsp_nxt = '0;
        rsp_nxt.pready = first_acc;
        rsp_nxt.pslverr = first_acc && !mapped;
        if (rd_acc && mapped) begin
            rsp_nxt.prdata = zext8(rd_byte);
        end
    end

    // Register file
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctl0_r <= `CTL0_RESET;
            ctl1_r <= `CTL1_RESET;
            src_sel_r <= `SRC_RESET;
            ovr_r <= `OVR_RESET;
        end else begin
            ctl0_r <= ctl0_nxt;
            ctl1_r <= ctl1_nxt;
            src_sel_r <= src_sel_nxt;
            ovr_r <= ovr_nxt;
        end
    end

    // Buffered settings
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctl1_act_r <= `CTL1_RESET;
            mode_act_r <= `MODE_RESET;
        end else begin
            ctl1_act_r <= ctl1_act_nxt;
            mode_act_r <= mode_act_nxt;
        end
    end

    // Input history and outputs
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            in_prev_r <= 1'b0;
            dir_r <= 1'b0;
            wave_r <= `WAVE_RESET;
        end else begin
            in_prev_r <= in_sig;
            dir_r <= dir_nxt;
            wave_r <= wave_nxt;
        end
    end

    // Bus answer
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rsp_r <= '0;
        end else begin
            rsp_r <= rsp_nxt;
        end
    end

    assign apb_o = rsp_r;
    assign wave_o = wave_r;
    assign enabled_o = ctl0_r[`CTL0_EN_BIT];

endmodule : waveform_gen_control
`default_nettype wire

// *** dv/bridge_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module bridge_model (
    // Gate drive from the controller
    input wire logic [3:0] gate_i,
    // Low-side switches, on while their gate is inactive
    output var logic [3:0] low_on_o
);
    assign low_on_o = ~gate_i;
endmodule : bridge_model
`default_nettype wire

// *** dv/wave_chk_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module wave_chk import wave_pkg::*; (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire apb_req_t apb_i,
    input wire apb_rsp_t apb_o,
    input wire logic enabled_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    wire tk = apb_i.psel & apb_i.penable & ~apb_o.pready;
    wire wr = apb_i.psel & apb_i.penable & apb_o.pready & apb_i.pwrite
        & apb_i.paddr == 12'h000;
    sequence s_rd; tk & !apb_i.pwrite & apb_i.paddr == 12'h000; endsequence
    property p_ans; tk |=> apb_o.pready; endproperty
    a_ans: assert property (p_ans) else $error("no ready");
    property p_one; apb_o.pready |=> !apb_o.pready; endproperty
    a_one: assert property (p_one) else $error("long ready");
    property p_err; apb_o.pslverr |-> apb_o.pready; endproperty
    a_err: assert property (p_err) else $error("stray error");
    property p_en; wr |=> enabled_o == $past(apb_i.pwdata[7]); endproperty
    a_en: assert property (p_en) else $error("enable");
    property p_hd; !wr |=> $stable(enabled_o); endproperty
    a_hd: assert property (p_hd) else $error("enable moved");
    property p_z; s_rd |=> apb_o.prdata[5:3] == 3'h0; endproperty
    a_z: assert property (p_z) else $error("unused bits");
    property p_ld; s_rd ##0 !enabled_o |=> !apb_o.prdata[6]; endproperty
    a_ld: assert property (p_ld) else $error("load kept");
    property p_rb; s_rd |=> apb_o.prdata[7] == enabled_o; endproperty
    a_rb: assert property (p_rb) else $error("enable read");
endmodule : wave_chk
bind waveform_gen_control wave_chk chk_u (.*);
`default_nettype wire

// *** dv/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import wave_pkg::*;
    logic clk_i = 0, rst = 1, sd = 0;
    logic [13:0] src = '0;
    logic [3:0] wv, lo;
    logic en_w;
    apb_req_t rq = '0;
    apb_rsp_t rs;
    int n_mismatch = 0, cmp_count = 0;
    waveform_gen_control dut_u (.clk_i(clk_i), .reset_i(rst), .apb_i(rq),
        .apb_o(rs), .sources_i(src), .shutdown_i(sd), .wave_o(wv),
        .enabled_o(en_w));
    bridge_model br_u (.gate_i(wv), .low_on_o(lo));
    initial forever #2.5 clk_i = ~clk_i;
    task automatic ck(logic [32:0] g, e);
        cmp_count++;
        n_mismatch += int'(g !== e);
        if (g !== e) $display("Error %0t %h %h", $time, g, e);
    endtask : ck
    task automatic xf(logic w, logic [11:0] a, logic [7:0] d,
        logic [32:0] e);
        rq <= '{1'b1, 1'b0, w, a, {24'h0, d}};
        @(posedge clk_i) rq.penable <= 1'b1;
        do @(posedge clk_i); while (rs.pready !== 1'b1);
        if (!w) ck({rs.pslverr, rs.prdata}, e);
        rq <= '0;
        @(posedge clk_i);
    endtask : xf
    task automatic complete_run(int late);
        n_mismatch += late;
        $display("done cmp %0d bad %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run
    initial #9000 complete_run(1);
    initial begin
        repeat (2) @(posedge clk_i);
        rst <= 1'b0;
        xf(1, 12'h000, 8'hFF, '0);
        xf(0, 12'h000, '0, 33'h87);
        xf(0, 12'h014, '0, 33'h100000000);
        for (int m = 0; m < 8; m++) begin
            xf(1, 12'h000, 8'(m), '0);
            xf(0, 12'h000, '0, 33'(m));
        end
        $display("test registers done");
        xf(1, 12'h004, 8'hF5, '0);
        xf(1, 12'h000, 8'h80, '0);
        @(negedge clk_i);
        ck(33'(wv), 33'hA);
        ck(33'(lo), 33'h5);
        ck(33'(en_w), 33'h1);
        xf(0, 12'h010, '0, 33'h0);
        $display("test polarity done");
        xf(1, 12'h004, 8'hF0, '0);
        xf(1, 12'h000, 8'hC0, '0);
        src <= 14'h1;
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        ck(33'(wv), 33'h0);
        xf(0, 12'h000, '0, 33'h80);
        $display("test load done");
        xf(1, 12'h008, 8'h0D, '0);
        xf(0, 12'h008, '0, 33'hD);
        xf(1, 12'h00C, 8'h03, '0);
        sd <= 1'b1;
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        ck(33'(wv), 33'h3);
        $display("test override done");
        complete_run(0);
    end
endmodule : testbench
`default_nettype wire
